// ===== hdl/slir_regs.sv
// Purpose: Safety-limit register that locks on the first write to another address, indicator configuration
//          register, limit clamping and indicator drive.
// Assumes: The serial interface hands over decoded writes and read addresses.
// Notes:   Limit-reset pin and short-battery comparator are asynchronous.
//
// Operation
// - Limit register at 06 resets to 0x40.
// - Upper nibble is maximum current code, bit6 set.
// - Lower nibble is maximum voltage code, zero default.
// - Voltage limit is 4.2 V plus code weight.
// - Current limit is 550 mA plus code weight.
// - Limit resets on short battery or pin low.
// - Limit writable until any other register written.
// - Clamp voltage and current codes to limits.
// - Early other write locks the default limits.
// - Indicator register at 07 resets to 0x82.
// - Bits 7:6 select indicator drive level.
// - Bit4 selects follow mode; bit5 reads zero.
// - Bits 3:2 select on time or constant.
// - Bits 1:0 select blink off time.
// - Voltage code is 3.5 V plus 20 mV steps.
// - Current code sits on 37.4 mV base.
`timescale 1ns/1ns
`default_nettype none
module slir_regs
  import slir_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Register write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Register read port
  input  wire logic [7:0] rd_addr,
  output logic      [7:0] rd_data,
  // Pins and comparators
  input  wire logic       limit_reset_pin_n,
  input  wire logic       short_battery_det,
  input  wire logic       charging_active,
  // Requested codes from the voltage and current registers
  input  wire logic [5:0] regulation_voltage_code,
  input  wire logic [3:0] charge_current_code,
  // Results
  output logic      [5:0] voltage_code_clamped,
  output logic      [3:0] current_code_clamped,
  output logic      [3:0] max_voltage_code,
  output logic      [3:0] max_current_code,
  output logic            limits_locked,
  output logic      [1:0] indicator_drive_level,
  output logic            indicator_on
);

  if (CYC_MS < 2) begin : g_bad_cyc_ms
    $error("slir_regs: CYC_MS must be at least 2");
  end

  typedef struct packed {
    logic [7:0] limit;
    logic [7:0] ind;
    logic       locked;
    logic [7:0] rd_data;
    logic [5:0] v_clamp;
    logic [3:0] i_clamp;
    logic [1:0] lrst_sync;
    logic [1:0] short_sync;
    logic [1:0] chg_sync;
  } slir_regs_state_t;

  slir_regs_state_t s_q;
  slir_regs_state_t s_d;
  logic             limit_rst;
  logic [5:0]       vlim_sum;
  logic [5:0]       vlim_code;
  logic [3:0]       ilim_code;
  logic             blink_en;

  // ----------------------------------------------------------------------
  // Limit decode
  // ----------------------------------------------------------------------
  // Only the second stage of each synchroniser is looked at.
  assign limit_rst = !s_q.lrst_sync[1] || s_q.short_sync[1];
  assign vlim_sum  = VLIM_OFFSET_CODE + {2'b00, s_q.limit[LIM_VOLT_HI:LIM_VOLT_LO]};
  // The nibbles reach past the highest usable option, so both limits saturate there.
  assign vlim_code = (vlim_sum > VLIM_TOP_CODE) ? VLIM_TOP_CODE : vlim_sum;
  // Both current scales share one base, so the limit nibble compares directly.
  assign ilim_code = (s_q.limit[LIM_CUR_HI:LIM_CUR_LO] > ILIM_TOP_CODE) ? ILIM_TOP_CODE
                                                                        : s_q.limit[LIM_CUR_HI:LIM_CUR_LO];

  // ----------------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.lrst_sync  = {s_q.lrst_sync[0], limit_reset_pin_n};
    s_d.short_sync = {s_q.short_sync[0], short_battery_det};
    s_d.chg_sync   = {s_q.chg_sync[0], charging_active};
    if (limit_rst) begin
      s_d.limit  = LIMIT_RST;
      s_d.locked = 1'b0;
    end else if (wr_en) begin
      if (wr_addr == ADDR_LIMIT) begin
        if (!s_q.locked) s_d.limit = wr_data;
      end else begin
        s_d.locked = 1'b1;
      end
    end
    if (wr_en && wr_addr == ADDR_IND) begin
      s_d.ind = wr_data & IND_RO_MASK;
    end
    unique case (rd_addr)
      ADDR_LIMIT: s_d.rd_data = s_q.limit;
      ADDR_IND:   s_d.rd_data = s_q.ind & IND_RO_MASK;
      default:    s_d.rd_data = READ_NONE;
    endcase
    s_d.v_clamp = (regulation_voltage_code > vlim_code) ? vlim_code
                                                        : regulation_voltage_code;
    s_d.i_clamp = (charge_current_code > ilim_code) ? ilim_code
                                                    : charge_current_code;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{limit: LIMIT_RST, ind: IND_RST, locked: 1'b0, rd_data: READ_NONE,
               v_clamp: '0, i_clamp: '0, lrst_sync: 2'b11, short_sync: 2'b00,
               chg_sync: 2'b00};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Indicator
  // ----------------------------------------------------------------------
  // Follow bit set runs the pattern without charging, clear needs charging; drive level off keeps the pattern dark.
  assign blink_en = (s_q.ind[IND_DRV_HI:IND_DRV_LO] != DRV_OFF) &&
                    (s_q.ind[IND_FOLLOW] || s_q.chg_sync[1]);

  slir_blink #(
    .CYC_MS (CYC_MS)
  ) u_blink (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .enable  (blink_en),
    .on_sel  (s_q.ind[IND_ON_HI:IND_ON_LO]),
    .off_sel (s_q.ind[IND_OFF_HI:IND_OFF_LO]),
    .lit     (indicator_on)
  );

  assign rd_data               = s_q.rd_data;
  assign voltage_code_clamped  = s_q.v_clamp;
  assign current_code_clamped  = s_q.i_clamp;
  assign max_voltage_code      = s_q.limit[LIM_VOLT_HI:LIM_VOLT_LO];
  assign max_current_code      = s_q.limit[LIM_CUR_HI:LIM_CUR_LO];
  assign limits_locked         = s_q.locked;
  assign indicator_drive_level = s_q.ind[IND_DRV_HI:IND_DRV_LO];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_pin_low_seen;
    !limit_reset_pin_n && !short_battery_det ##1 !limit_reset_pin_n;
  endsequence

  sequence s_other_write;
    wr_en && wr_addr != ADDR_LIMIT;
  endsequence

  chk_pin_resets_limit: assert property (
    s_pin_low_seen |-> ##2 s_q.limit == LIMIT_RST && !limits_locked)
    else $error("limit not restored two edges after pin low");

  chk_limit_reset_value: assert property (
    limit_rst |=> max_current_code == 4'h4 && max_voltage_code == 4'h0)
    else $error("limit reset value wrong");

  chk_other_write_locks: assert property (
    s_other_write ##0 !limit_rst |=> limits_locked)
    else $error("write to other register did not lock limits");

  chk_locked_holds: assert property (
    limits_locked && !limit_rst |=> $stable(s_q.limit))
    else $error("locked limit register changed");

  chk_default_locked: assert property (
    s_q.limit == LIMIT_RST ##0 s_other_write ##0 !limit_rst
      |=> limits_locked ##1 (s_q.limit == LIMIT_RST || limit_rst || $past(limit_rst)))
    else $error("defaults not kept after early lock");

  chk_volt_clamp: assert property (
    1'b1 |=> voltage_code_clamped <= $past(vlim_code) &&
             voltage_code_clamped <= $past(regulation_voltage_code))
    else $error("voltage code exceeds limit");

  chk_curr_clamp: assert property (
    1'b1 |=> current_code_clamped <= $past(ilim_code) &&
             current_code_clamped <= $past(charge_current_code))
    else $error("current code exceeds limit");

  chk_volt_top_cap: assert property (
    1'b1 |=> voltage_code_clamped <= VLIM_TOP_CODE)
    else $error("voltage code above highest usable limit");

  chk_curr_top_cap: assert property (
    1'b1 |=> current_code_clamped <= ILIM_TOP_CODE)
    else $error("current code above highest usable limit");

  chk_ind_zero_bit: assert property (
    rd_addr == ADDR_IND |=> rd_data[IND_ZERO] == 1'b0)
    else $error("indicator bit 5 read as one");

  chk_drive_off_dark: assert property (
    indicator_drive_level == DRV_OFF ##1 indicator_drive_level == DRV_OFF |=> !indicator_on)
    else $error("indicator lit with drive off");

endmodule
`default_nettype wire

// ===== hdl/slir_pkg.sv
// Purpose: Shared constants for the safety-limit and indicator register bank.
// Assumes: 250 MHz reference clock, 8-bit registers on an 8-bit address map.
// Notes:   Voltages in mV, currents in mA, durations in ms.
package slir_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_VOLT   = 8'h02;
  localparam logic [7:0] ADDR_CURR   = 8'h04;
  localparam logic [7:0] ADDR_LIMIT  = 8'h06;
  localparam logic [7:0] ADDR_IND    = 8'h07;
  localparam logic [7:0] LIMIT_RST   = 8'h40;
  localparam logic [7:0] IND_RST     = 8'h82;
  localparam logic [7:0] IND_RO_MASK = 8'hDF;
  localparam logic [7:0] READ_NONE   = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LIM_CUR_HI  = 7;
  localparam int LIM_CUR_LO  = 4;
  localparam int LIM_VOLT_HI = 3;
  localparam int LIM_VOLT_LO = 0;
  localparam int IND_DRV_HI  = 7;
  localparam int IND_DRV_LO  = 6;
  localparam int IND_ZERO    = 5;
  localparam int IND_FOLLOW  = 4;
  localparam int IND_ON_HI   = 3;
  localparam int IND_ON_LO   = 2;
  localparam int IND_OFF_HI  = 1;
  localparam int IND_OFF_LO  = 0;

  // ----------------------------------------------------------------------
  // Analog scaling
  // ----------------------------------------------------------------------
  localparam int VREG_BASE_MV  = 3500;
  localparam int VLIM_BASE_MV  = 4200;
  localparam int VSTEP_MV      = 20;
  localparam int VLIM_TOP_MV   = 4440;
  localparam int ILIM_BASE_MA  = 550;
  localparam int ILIM_TOP_MA   = 1550;
  localparam logic [5:0] VLIM_OFFSET_CODE = 6'((VLIM_BASE_MV - VREG_BASE_MV) / VSTEP_MV);
  localparam int ILIM_STEP_MA  = 100;
  // Highest usable limits, in the units of the voltage and current request codes.
  localparam logic [5:0] VLIM_TOP_CODE = 6'((VLIM_TOP_MV - VREG_BASE_MV) / VSTEP_MV);
  localparam logic [3:0] ILIM_TOP_CODE = 4'((ILIM_TOP_MA - ILIM_BASE_MA) / ILIM_STEP_MA);

  // ----------------------------------------------------------------------
  // Indicator codes and timing
  // ----------------------------------------------------------------------
  localparam logic [1:0] DRV_OFF      = 2'b00;
  localparam logic [1:0] ON_CONSTANT  = 2'b11;
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS         = 1_000_000;
  localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
  localparam logic [11:0] ON_MS_0  = 12'h000D;
  localparam logic [11:0] ON_MS_1  = 12'h0104;
  localparam logic [11:0] ON_MS_2  = 12'h0208;
  localparam logic [11:0] OFF_MS_0 = 12'h0186;
  localparam logic [11:0] OFF_MS_1 = 12'h030C;
  localparam logic [11:0] OFF_MS_2 = 12'h0618;
  localparam logic [11:0] OFF_MS_3 = 12'h0C30;

endpackage

// ===== hdl/slir_blink.sv
// Purpose: Indicator blink generator on a millisecond timebase.
// Assumes: enable and the duration codes come from the same clock domain.
// Notes:   The pattern restarts in its on phase whenever enable rises.
`timescale 1ns/1ns
`default_nettype none
module slir_blink
  import slir_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       enable,
  input  wire logic [1:0] on_sel,
  input  wire logic [1:0] off_sel,
  // Indicator
  output logic            lit
);

  if (CYC_MS < 2) begin : g_bad_cyc_ms
    $error("slir_blink: CYC_MS must be at least 2");
  end

  localparam int DW = $clog2(CYC_MS);

  typedef enum logic {PH_ON, PH_OFF} slir_phase_t;

  typedef struct packed {
    logic [DW-1:0] div;
    logic [11:0]   ms;
    slir_phase_t   phase;
    logic          lit;
  } slir_blink_state_t;

  slir_blink_state_t s_q;
  slir_blink_state_t s_d;
  logic              tick;
  logic [11:0]       on_ms;
  logic [11:0]       off_ms;

  always_comb begin
    unique case (on_sel)
      2'b00:   on_ms = ON_MS_0;
      2'b01:   on_ms = ON_MS_1;
      default: on_ms = ON_MS_2;
    endcase
    unique case (off_sel)
      2'b00:   off_ms = OFF_MS_0;
      2'b01:   off_ms = OFF_MS_1;
      2'b10:   off_ms = OFF_MS_2;
      default: off_ms = OFF_MS_3;
    endcase
  end

  assign tick = (s_q.div == DW'(CYC_MS - 1));

  // ----------------------------------------------------------------------
  // Timebase and phase sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.div = tick ? '0 : s_q.div + 1'b1;
    if (!enable) begin
      s_d.phase = PH_ON;
      s_d.ms    = '0;
      s_d.lit   = 1'b0;
    end else if (on_sel == ON_CONSTANT) begin
      s_d.phase = PH_ON;
      s_d.ms    = '0;
      s_d.lit   = 1'b1;
    end else begin
      s_d.lit = (s_q.phase == PH_ON);
      if (tick) begin
        unique case (s_q.phase)
          PH_ON: begin
            if (s_q.ms + 1'b1 >= on_ms) begin
              s_d.phase = PH_OFF;
              s_d.ms    = '0;
            end else begin
              s_d.ms = s_q.ms + 1'b1;
            end
          end
          PH_OFF: begin
            if (s_q.ms + 1'b1 >= off_ms) begin
              s_d.phase = PH_ON;
              s_d.ms    = '0;
            end else begin
              s_d.ms = s_q.ms + 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{div: '0, ms: '0, phase: PH_ON, lit: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign lit = s_q.lit;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_constant_on_lit: assert property (
    enable && on_sel == ON_CONSTANT |=> lit)
    else $error("constant-on code did not light the indicator");

  chk_disabled_dark: assert property (
    !enable |=> !lit)
    else $error("indicator lit while disabled");

endmodule
`default_nettype wire

// ===== testbench/slir_host.sv
// Purpose: Host model that writes and reads the register bank.
// Assumes: One write strobe cycle per access, reads answered a cycle late.
// Notes:   Idle write data shows the inverse of the last byte sent.
`timescale 1ns/1ns
`default_nettype none
module slir_host (
  // Clock
  input  wire logic       ref_clk,
  // Register port
  output logic            wr_en,
  output logic      [7:0] wr_addr,
  output logic      [7:0] wr_data,
  output logic      [7:0] rd_addr,
  input  wire logic [7:0] rd_data
);
  initial begin
    wr_en   = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    rd_addr = 8'h00;
  end

  // Normal use programs the limit byte before any other address.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en   <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
    wr_data <= ~d;
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    rd_addr <= a;
    repeat (2) @(posedge ref_clk);
    #1 d = rd_data;
  endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the limit and indicator registers.
// Assumes: Millisecond tick shortened to four clocks.
// Notes:   Blink phases are measured after the first on phase that follows a restart.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import slir_pkg::*;
  localparam int CMS = 4;
  logic       ref_clk, rst_n, pin_n, short_det, chg, wr_en, locked, lit;
  logic [7:0] wr_addr, wr_data, rd_addr, rd_data, lim, rv;
  logic [5:0] vreq, vcl;
  logic [3:0] creq, ccl, mv, mc;
  logic [1:0] drv;
  int         fail_count, n_tests, len, k, on_t[3], off_t[4];

  slir_host host_u (.ref_clk(ref_clk), .wr_en(wr_en), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data));
  slir_regs #(.CYC_MS(CMS)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .limit_reset_pin_n(pin_n), .short_battery_det(short_det),
    .charging_active(chg), .regulation_voltage_code(vreq),
    .charge_current_code(creq), .voltage_code_clamped(vcl),
    .current_code_clamped(ccl), .max_voltage_code(mv), .max_current_code(mc),
    .limits_locked(locked), .indicator_drive_level(drv), .indicator_on(lit));

  always #2 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------------
  // Checks and helpers
  // ----------------------------------------------------------------------
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_len(input int got, input int exp);
    n_tests++;
    if (got != exp) begin
      fail_count++;
      $display("[FAIL] %0t phase %0d cycles expected %0d", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [5:0] exp_v(input logic [5:0] v, input logic [7:0] l);
    logic [5:0] top;
    top = VLIM_OFFSET_CODE + 6'(l[3:0]);
    if (top > VLIM_TOP_CODE) top = VLIM_TOP_CODE;
    return (v > top) ? top : v;
  endfunction

  function automatic logic [3:0] exp_c(input logic [3:0] c, input logic [7:0] l);
    logic [3:0] top;
    top = (l[7:4] > ILIM_TOP_CODE) ? ILIM_TOP_CODE : l[7:4];
    return (c > top) ? top : c;
  endfunction

  task automatic chk_lim();
    repeat (2) @(posedge ref_clk);
    #1;
    check_val(8'(mc), 8'(lim[7:4]));
    check_val(8'(mv), 8'(lim[3:0]));
    host_u.read(ADDR_LIMIT, rv);
    check_val(rv, lim);
  endtask

  task automatic clamp(input logic [5:0] v, input logic [3:0] c);
    @(posedge ref_clk);
    vreq <= v;
    creq <= c;
    repeat (2) @(posedge ref_clk);
    #1;
    check_val(8'(vcl), 8'(exp_v(v, lim)));
    check_val(8'(ccl), 8'(exp_c(c, lim)));
  endtask

  task automatic run_len(input logic v, output int n);
    n = 0;
    while (lit === v && n < 20000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= 20000) begin
      fail_count++;
      $display("[FAIL] %0t indicator phase never ended", $time);
      end_sim();
    end
  endtask

  task automatic wait_lit(input logic v, input int bound);
    len = 0;
    while (lit !== v && len < bound) begin
      @(posedge ref_clk);
      #1 len++;
    end
    if (lit !== v) begin
      fail_count++;
      $display("[FAIL] %0t indicator wait ran out", $time);
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 0; rst_n = 0; pin_n = 1; short_det = 0; chg = 0;
    vreq = 6'h3f; creq = 4'hf; fail_count = 0; n_tests = 0; lim = LIMIT_RST;
    on_t = '{13, 260, 520};
    off_t = '{390, 780, 1560, 3120};
    void'($urandom(28190));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 check_val(8'(drv), 8'h02);
    chk_lim();
    host_u.read(ADDR_IND, rv);
    check_val(rv, IND_RST);
    host_u.read(8'h03, rv);
    check_val(rv, READ_NONE);
    host_u.write(ADDR_IND, IND_RST);
    host_u.write(ADDR_LIMIT, 8'hff);
    chk_lim();
    check_val(8'(locked), 8'h01);
    clamp(6'h3f, 4'hf);
    for (int w = 0; w < 2; w++) begin
      @(posedge ref_clk);
      if (w == 0) pin_n <= 1'b0;
      else short_det <= 1'b1;
      repeat (4) @(posedge ref_clk);
      pin_n <= 1'b1;
      short_det <= 1'b0;
      lim = LIMIT_RST;
      chk_lim();
      check_val(8'(locked), 8'h00);
      repeat (3) begin
        lim = (w == 1) ? 8'hff : 8'($urandom);
        host_u.write(ADDR_LIMIT, lim);
        chk_lim();
      end
      host_u.write(ADDR_VOLT, 8'($urandom));
      host_u.write(ADDR_LIMIT, ~lim);
      chk_lim();
      clamp(6'h3f, 4'hf);
      repeat (12) clamp(6'($urandom), 4'($urandom));
    end
    host_u.write(ADDR_IND, 8'hff);
    host_u.read(ADDR_IND, rv);
    check_val(rv, 8'hdf);
    for (k = 0; k < 4; k++) begin
      host_u.write(ADDR_IND, {2'(k), 6'h1c});
      repeat (3) @(posedge ref_clk);
      #1 check_val(8'(drv), 8'(k));
      check_val(8'(lit), 8'(k != 0));
    end
    host_u.write(ADDR_IND, 8'h8c);
    repeat (6) @(posedge ref_clk);
    #1 check_val(8'(lit), 8'h00);
    chg <= 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 check_val(8'(lit), 8'h01);
    for (k = 0; k < 4; k++) begin
      host_u.write(ADDR_IND, 8'h00);
      host_u.write(ADDR_IND, {4'h9, 2'(k % 3), 2'(k)});
      wait_lit(1'b1, 4 * CMS);
      wait_lit(1'b0, (on_t[k % 3] + 2) * CMS);
      run_len(1'b0, len);
      check_len(len, off_t[k] * CMS);
      run_len(1'b1, len);
      check_len(len, on_t[k % 3] * CMS);
    end
    end_sim();
  end
endmodule
`default_nettype wire
